/* hw/eew_slave.sv */
// Purpose: Slave side of a 2 Kbit two-wire EEPROM bus interface
// Assumes: Array and program timer sit outside, joined by the memory port
// Notes: Bus lines and pins pass two flops before use
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module eew_slave #(
  parameter logic [3:0] DEV_TYPE = 4'h5 // Arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe_n,
  input wire logic [2:0] i_sel_pins,
  input wire logic i_wp,
  input wire logic i_busy,
  input wire logic [7:0] i_rd_data,
  output var eew_pkg::eew_mem_t o_mem,
  output logic o_standby,
  input wire logic [1:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata
);

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic [2:0] sel_m;
    logic [2:0] sel_s;
    logic wp_m;
    logic wp_s;
    eew_pkg::eew_state_t state;
    eew_pkg::eew_state_t after;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic drive_low;
    logic [7:0] addr;
    logic mack;
    logic wrote;
    logic load;
    logic standby;
    logic pend_stby;
    logic en;
    logic wr;
    logic rd;
    logic prog;
    logic [7:0] rdata;
  } eew_regs_t;

  eew_regs_t r_reg;
  eew_regs_t r_next;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  logic dev_hit;
  logic protect;

  // ----------------------------------------
  // Bus conditions
  // ----------------------------------------
  assign scl_rise = r_reg.scl_s & ~r_reg.scl_p;
  assign scl_fall = ~r_reg.scl_s & r_reg.scl_p;
  assign start_evt = r_reg.scl_s & r_reg.scl_p & r_reg.sda_p & ~r_reg.sda_s;
  assign stop_evt = r_reg.scl_s & r_reg.scl_p & ~r_reg.sda_p & r_reg.sda_s;
  // Type and select pins; all three pins present, so one page block
  assign dev_hit = (r_reg.shreg[7:4] == DEV_TYPE) && (r_reg.shreg[3:1] == r_reg.sel_s) && !i_busy;
  assign protect = r_reg.wp_s && r_reg.addr[eew_pkg::EEW_UPPER_BIT];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.scl_m = i_scl;
    r_next.scl_s = r_reg.scl_m;
    r_next.scl_p = r_reg.scl_s;
    r_next.sda_m = i_sda;
    r_next.sda_s = r_reg.sda_m;
    r_next.sda_p = r_reg.sda_s;
    r_next.sel_m = i_sel_pins;
    r_next.sel_s = r_reg.sel_m;
    r_next.wp_m = i_wp;
    r_next.wp_s = r_reg.wp_m;
    r_next.wr = 1'b0;
    r_next.rd = 1'b0;
    r_next.prog = 1'b0;
    r_next.rdata = 8'h00;
    if (i_reg_wr && i_reg_addr == eew_pkg::EEW_REG_CTRL) begin
      r_next.en = i_reg_wdata[eew_pkg::EEW_CTRL_EN_BIT];
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        eew_pkg::EEW_REG_CTRL: r_next.rdata = {7'h00, r_reg.en};
        eew_pkg::EEW_REG_STAT: r_next.rdata = {r_reg.state, r_reg.pend_stby, r_reg.standby, i_busy, r_reg.drive_low,
                                               r_reg.wp_s};
        eew_pkg::EEW_REG_ADDR: r_next.rdata = r_reg.addr;
        default: r_next.rdata = 8'h00;
      endcase
    end
    // Address counter follows each array access
    if (r_reg.wr) begin
      r_next.addr[3:0] = r_reg.addr[3:0] + 4'h1;
    end
    if (r_reg.rd) begin
      r_next.addr = r_reg.addr + 8'h01;
    end
    if (r_reg.load) begin
      r_next.load = 1'b0;
      r_next.shreg = i_rd_data;
      r_next.drive_low = ~i_rd_data[7];
      r_next.bit_cnt = 4'h0;
    end
    if (stop_evt) begin
      r_next.state = eew_pkg::EEW_ST_IDLE;
      r_next.drive_low = 1'b0;
      r_next.load = 1'b0;
      if (r_reg.wrote) begin
        r_next.prog = 1'b1;
        r_next.pend_stby = 1'b1;
        r_next.wrote = 1'b0;
      end else if (!i_busy) begin
        r_next.standby = 1'b1;
        r_next.pend_stby = 1'b0;
      end
    end else if (start_evt) begin
      r_next.drive_low = 1'b0;
      r_next.load = 1'b0;
      if (r_reg.en && !i_busy) begin
        r_next.state = eew_pkg::EEW_ST_DEVADR;
        r_next.bit_cnt = 4'h0;
        r_next.standby = 1'b0;
      end else begin
        r_next.state = eew_pkg::EEW_ST_IDLE;
      end
    end else begin
      case (r_reg.state)
        eew_pkg::EEW_ST_IDLE: begin
          r_next.drive_low = 1'b0;
        end
        eew_pkg::EEW_ST_DEVADR, eew_pkg::EEW_ST_WORDADR, eew_pkg::EEW_ST_DATA: begin
          if (scl_rise) begin
            r_next.shreg = {r_reg.shreg[6:0], r_reg.sda_s};
            r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
          end else if (scl_fall && r_reg.bit_cnt == eew_pkg::EEW_BIT_LAST) begin
            r_next.bit_cnt = 4'h0;
            r_next.state = eew_pkg::EEW_ST_ACK;
            if (r_reg.state == eew_pkg::EEW_ST_DEVADR) begin
              r_next.drive_low = dev_hit;
              r_next.after = !dev_hit ? eew_pkg::EEW_ST_IDLE :
                             r_reg.shreg[0] ? eew_pkg::EEW_ST_TX : eew_pkg::EEW_ST_WORDADR;
            end else if (r_reg.state == eew_pkg::EEW_ST_WORDADR) begin
              r_next.drive_low = 1'b1;
              r_next.addr = r_reg.shreg;
              r_next.after = eew_pkg::EEW_ST_DATA;
            end else if (protect) begin
              r_next.drive_low = 1'b0;
              r_next.after = eew_pkg::EEW_ST_WAIT;
            end else begin
              r_next.drive_low = 1'b1;
              r_next.wr = 1'b1;
              r_next.wrote = 1'b1;
              r_next.after = eew_pkg::EEW_ST_DATA;
            end
          end
        end
        eew_pkg::EEW_ST_ACK: begin
          if (scl_fall) begin
            r_next.drive_low = 1'b0;
            r_next.state = r_reg.after;
            if (r_reg.after == eew_pkg::EEW_ST_TX) begin
              r_next.rd = 1'b1;
              r_next.load = 1'b1;
            end
          end
        end
        eew_pkg::EEW_ST_TX: begin
          if (scl_rise) begin
            r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
          end else if (scl_fall && !r_reg.load) begin
            if (r_reg.bit_cnt == eew_pkg::EEW_BIT_LAST) begin
              r_next.drive_low = 1'b0;
              r_next.state = eew_pkg::EEW_ST_MACK;
            end else begin
              r_next.shreg = {r_reg.shreg[6:0], 1'b0};
              r_next.drive_low = ~r_reg.shreg[6];
            end
          end
        end
        eew_pkg::EEW_ST_MACK: begin
          if (scl_rise) begin
            r_next.mack = ~r_reg.sda_s;
          end else if (scl_fall) begin
            if (r_reg.mack) begin
              r_next.state = eew_pkg::EEW_ST_TX;
              r_next.rd = 1'b1;
              r_next.load = 1'b1;
            end else begin
              r_next.state = eew_pkg::EEW_ST_WAIT;
            end
          end
        end
        eew_pkg::EEW_ST_WAIT: begin
          r_next.drive_low = 1'b0;
        end
        default: begin
          r_next.state = eew_pkg::EEW_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      r_reg <= '0;
      r_reg.scl_m <= 1'b1;
      r_reg.scl_s <= 1'b1;
      r_reg.scl_p <= 1'b1;
      r_reg.sda_m <= 1'b1;
      r_reg.sda_s <= 1'b1;
      r_reg.sda_p <= 1'b1;
      r_reg.standby <= 1'b1;
      r_reg.en <= eew_pkg::EEW_CTRL_EN_RST;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_sda_o = 1'b0;
  assign o_sda_oe_n = ~r_reg.drive_low;
  assign o_mem.addr = r_reg.addr;
  assign o_mem.wdata = r_reg.shreg;
  assign o_mem.wr = r_reg.wr;
  assign o_mem.rd = r_reg.rd;
  assign o_mem.prog = r_reg.prog;
  assign o_standby = r_reg.standby;
  assign o_reg_rdata = r_reg.rdata;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n || !i_ce);

  sequence s_byte_done;
    scl_fall && r_reg.bit_cnt == eew_pkg::EEW_BIT_LAST;
  endsequence

  sequence s_in_devadr;
    r_reg.state == eew_pkg::EEW_ST_DEVADR && !start_evt && !stop_evt;
  endsequence

  sequence s_in_word;
    r_reg.state == eew_pkg::EEW_ST_WORDADR && !start_evt && !stop_evt;
  endsequence

  sequence s_in_data;
    r_reg.state == eew_pkg::EEW_ST_DATA && !start_evt && !stop_evt;
  endsequence

  sequence s_in_tx;
    r_reg.state == eew_pkg::EEW_ST_TX && !r_reg.load && !start_evt && !stop_evt;
  endsequence

  sequence s_mack_fall;
    r_reg.state == eew_pkg::EEW_ST_MACK && scl_fall && !start_evt && !stop_evt;
  endsequence

  open_drain_a: assert property (o_sda_o == 1'b0)
    else $error("data line driven high");
  drive_clk_low_a: assert property ($rose(r_reg.drive_low) |-> !r_reg.scl_s)
    else $error("data drive began with clock high");
  start_seen_a: assert property (start_evt && r_reg.en && !i_busy |=> r_reg.state == eew_pkg::EEW_ST_DEVADR)
    else $error("start not taken");
  stop_seen_a: assert property (stop_evt |=> r_reg.state == eew_pkg::EEW_ST_IDLE && !r_reg.drive_low)
    else $error("stop did not end transfer");
  busy_ignore_a: assert property (start_evt && i_busy |=> r_reg.state == eew_pkg::EEW_ST_IDLE)
    else $error("start accepted while busy");
  type_miss_a: assert property (s_in_devadr ##0 s_byte_done ##0 (r_reg.shreg[7:4] != DEV_TYPE)
                                |=> !r_reg.drive_low)
    else $error("ack given to foreign type");
  addr_ack_a: assert property (s_in_devadr ##0 s_byte_done ##0 dev_hit |=> r_reg.drive_low ##0
                               r_reg.state == eew_pkg::EEW_ST_ACK)
    else $error("matching address not acked");
  wp_block_a: assert property (r_reg.wr |-> !(r_reg.wp_s && r_reg.addr[eew_pkg::EEW_UPPER_BIT]))
    else $error("write into protected half");
  page_roll_a: assert property (r_reg.wr |=> r_reg.addr == {$past(r_reg.addr[7:4]), $past(r_reg.addr[3:0]) + 4'h1})
    else $error("page counter wrong");
  read_inc_a: assert property (r_reg.rd && !start_evt && !stop_evt |=> r_reg.addr == $past(r_reg.addr) + 8'h01)
    else $error("read counter wrong");
  ack_release_a: assert property (r_reg.state == eew_pkg::EEW_ST_ACK && scl_fall && !stop_evt && !start_evt
                                  |=> !r_reg.drive_low)
    else $error("ack held past ninth clock");

  sel_miss_a: assert property (s_in_devadr ##0 s_byte_done ##0 (r_reg.shreg[3:1] != r_reg.sel_s)
                               |=> !r_reg.drive_low)
    else $error("ack given to other select code");
  read_dir_a: assert property (s_in_devadr ##0 s_byte_done ##0 dev_hit ##0 r_reg.shreg[0]
                               |=> r_reg.after == eew_pkg::EEW_ST_TX)
    else $error("read request not taken");
  write_dir_a: assert property (s_in_devadr ##0 s_byte_done ##0 dev_hit ##0 !r_reg.shreg[0]
                                |=> r_reg.after == eew_pkg::EEW_ST_WORDADR)
    else $error("write request not taken");
  word_ack_a: assert property (s_in_word ##0 s_byte_done
                               |=> r_reg.drive_low && r_reg.addr == $past(r_reg.shreg))
    else $error("word address not taken");
  data_ack_a: assert property (s_in_data ##0 s_byte_done ##0 !protect |=> r_reg.wr && r_reg.drive_low)
    else $error("data byte not acked");
  data_nack_a: assert property (s_in_data ##0 s_byte_done ##0 protect |=> !r_reg.wr && !r_reg.drive_low)
    else $error("protected byte acked");
  tx_release_a: assert property (s_in_tx ##0 s_byte_done
                                 |=> !r_reg.drive_low && r_reg.state == eew_pkg::EEW_ST_MACK)
    else $error("line held after eighth bit");
  mack_next_a: assert property (s_mack_fall ##0 r_reg.mack |=> r_reg.rd && r_reg.load)
    else $error("next byte not fetched");
  nack_wait_a: assert property (s_mack_fall ##0 !r_reg.mack |=> r_reg.state == eew_pkg::EEW_ST_WAIT)
    else $error("sending went on without ack");
  wait_quiet_a: assert property (r_reg.state == eew_pkg::EEW_ST_WAIT |-> !r_reg.drive_low)
    else $error("line driven while waiting for stop");
  idle_quiet_a: assert property (r_reg.state == eew_pkg::EEW_ST_IDLE |-> !r_reg.drive_low)
    else $error("line driven while idle");
  prog_stop_a: assert property (stop_evt && r_reg.wrote |=> r_reg.prog && !r_reg.standby)
    else $error("write not launched at stop");
  stop_stby_a: assert property (stop_evt && !r_reg.wrote && !i_busy |=> r_reg.standby)
    else $error("stop did not give standby");
  busy_stby_a: assert property (stop_evt && !r_reg.wrote && i_busy |=> $stable(r_reg.standby))
    else $error("standby changed during program");
  read_load_a: assert property (r_reg.load && !start_evt && !stop_evt |=> r_reg.shreg == $past(i_rd_data))
    else $error("read byte not loaded");

endmodule

`default_nettype wire

/* hw/eew_pkg.sv */
// Purpose: Constants and types for the two-wire EEPROM slave front end
// Assumes: One system clock samples the bus lines and the strap pins
// Notes: Overview list of behaviour follows
// Overview of operation
// - Word address picks one of 256 bytes
// - Pages are 16 aligned bytes
// - Page block is 16 pages of 16 bytes
// - Data line only pulled low or released
// - Protect pin blocks upper half programming
// - Protected: address acked, data not acked
// - Select bits compared with select pins
// - Missing select pin picks page block
// - Data changes only while clock low
// - Start is data fall, clock high
// - Stop is data rise, clock high
// - Second stop after program enters standby; here only if the program cycle has ended by then
// - Ack matching slave address
// - Ack every written byte
// - Read: eight bits, then sample ack
// - No ack: release, wait for stop
// - Top four address bits are type
// - Address LSB: 1 read, 0 write
// - Receiver pulls data low ninth clock
// - Busy program cycle: no ack, released
package eew_pkg;

  // ----------------------------------------
  // Register port map
  // ----------------------------------------
  localparam logic [1:0] EEW_REG_CTRL = 2'h0;
  localparam logic [1:0] EEW_REG_STAT = 2'h1;
  localparam logic [1:0] EEW_REG_ADDR = 2'h2;
  localparam int EEW_CTRL_EN_BIT = 0;
  localparam logic EEW_CTRL_EN_RST = 1'b1;

  // ----------------------------------------
  // Array layout
  // ----------------------------------------
  localparam int EEW_ADDR_W = 8;
  localparam int EEW_PAGE_W = 4;
  localparam int EEW_SEL_W = 3;
  localparam int EEW_UPPER_BIT = 7;
  localparam logic [3:0] EEW_BIT_LAST = 4'h8;

  // ----------------------------------------
  // Bus states
  // ----------------------------------------
  typedef enum logic [2:0] {
    EEW_ST_IDLE = 3'b000,
    EEW_ST_DEVADR = 3'b001,
    EEW_ST_WORDADR = 3'b010,
    EEW_ST_DATA = 3'b011,
    EEW_ST_ACK = 3'b100,
    EEW_ST_TX = 3'b101,
    EEW_ST_MACK = 3'b110,
    EEW_ST_WAIT = 3'b111
  } eew_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic prog;
  } eew_mem_t;

endpackage

/* sim/eew_bus_master.sv */
// Purpose: Bus master model clocking the two-wire link
// Assumes: Link period of 320 ns, 8 system clocks
// Notes: Data output 1 releases the line to the pull-up
`timescale 1ns/100ps
`default_nettype none
module eew_bus_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda,
  output logic o_res_v,
  output logic [7:0] o_res
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    o_res_v = 1'b0;
    o_res = 8'h00;
  end
  // Quarter period step; clock stands high between frames
  task automatic q(input logic c, input logic d);
    repeat (2) @(posedge i_clk);
    o_scl <= c;
    o_sda <= d;
  endtask
  task automatic bit_io(input logic b, output logic s);
    q(1'b0, o_sda);
    q(1'b0, b);
    q(1'b1, b);
    repeat (2) @(posedge i_clk);
    #1 s = i_sda;
  endtask
  task automatic start();
    q(1'b0, o_sda);
    q(1'b0, 1'b1);
    q(1'b1, 1'b1);
    q(1'b1, 1'b0);
  endtask
  task automatic stop();
    q(1'b0, o_sda);
    q(1'b0, 1'b0);
    q(1'b1, 1'b0);
    q(1'b1, 1'b1);
  endtask
  task automatic rep(input logic [7:0] v);
    o_res <= v;
    o_res_v <= 1'b1;
    @(posedge i_clk);
    o_res_v <= 1'b0;
  endtask
  task automatic put(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    rep({7'h00, s});
  endtask
  task automatic get(input logic nack);
    logic [7:0] v;
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(nack, s);
    rep(v);
  endtask
endmodule
`default_nettype wire

/* sim/test_eew_slave.sv */
// Purpose: Self-checking bench for the two-wire EEPROM slave
// Assumes: Array and program timer modelled here
// Notes: Link results are checked against a queue of notes
`timescale 1ns/100ps
`default_nettype none
module test_eew_slave;
  localparam logic [3:0] DT = 4'h6; // Arbitrary type value
  localparam logic [2:0] SEL = 3'b101;
  logic i_clk = 1'b0, rst_n = 1'b0, wp = 1'b0, busy = 1'b0, rwr = 1'b0, rrd = 1'b0, ce = 1'b1;
  logic scl, m_sda, res_v, oe_n, sda_o, standby;
  logic [7:0] wdata = 8'h00, res, rdata, rd_data;
  logic [1:0] raddr = 2'h0;
  logic [2:0] sel = SEL;
  eew_pkg::eew_mem_t mem;
  wire logic sda = m_sda & (oe_n | sda_o);
  logic [7:0] arr [256], ref_m [256], q [$];
  // Array answers in the cycle of the read pulse
  assign rd_data = arr[mem.addr];
  int err_count = 0, num_checks = 0, progs = 0, bcnt = 0;
  logic [31:0] seed = 32'h0fcfd955;
  always #20 i_clk = ~i_clk;
  eew_slave #(.DEV_TYPE(DT)) i_dut (.i_clk(i_clk), .i_rst_n(rst_n), .i_ce(ce), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe_n(oe_n), .i_sel_pins(sel), .i_wp(wp), .i_busy(busy), .i_rd_data(rd_data),
    .o_mem(mem), .o_standby(standby), .i_reg_addr(raddr), .i_reg_wdata(wdata), .i_reg_wr(rwr),
    .i_reg_rd(rrd), .o_reg_rdata(rdata));
  eew_bus_master i_mst (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda), .o_res_v(res_v), .o_res(res));
  always @(posedge i_clk) begin
    if (mem.wr) arr[mem.addr] <= mem.wdata;
    if (mem.prog) progs <= progs + 1;
    bcnt <= mem.prog ? 150 : (bcnt > 0 ? bcnt - 1 : 0);
    busy <= mem.prog || bcnt > 1;
  end
  always @(posedge i_clk) begin
    if (res_v) chk("link", res, q.size() > 0 ? q.pop_front() : 8'hxx);
  end
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  function automatic logic [7:0] lf();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic reg_io(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    raddr <= a;
    wdata <= d;
    rwr <= w;
    rrd <= !w;
    @(posedge i_clk);
    rwr <= 1'b0;
    rrd <= 1'b0;
    #1;
  endtask
  task automatic snd(input logic [7:0] b, input logic ack_n);
    q.push_back({7'h00, ack_n});
    i_mst.put(b);
  endtask
  task automatic probe(input logic [7:0] b);
    i_mst.start();
    snd(b, 1'b1);
    i_mst.stop();
  endtask
  task automatic wr_seq(input logic [7:0] a, input int n, input logic ok);
    logic [7:0] d;
    i_mst.start();
    snd({DT, SEL, 1'b0}, 1'b0);
    snd(a, 1'b0);
    for (int k = 0; k < n; k++) begin
      d = lf();
      if (ok) ref_m[{a[7:4], a[3:0] + 4'(k)}] = d;
      snd(d, !ok);
    end
    i_mst.stop();
    repeat (5) @(posedge i_clk);
  endtask
  task automatic rd_seq(input logic [7:0] a, input int n);
    i_mst.start();
    snd({DT, SEL, 1'b0}, 1'b0);
    snd(a, 1'b0);
    i_mst.start();
    snd({DT, SEL, 1'b1}, 1'b0);
    for (int k = 0; k < n; k++) begin
      q.push_back(ref_m[8'(a + k)]);
      i_mst.get(k == n - 1);
    end
    i_mst.stop();
  endtask
  initial begin
    for (int i = 0; i < 256; i++) begin
      arr[i] = lf();
      ref_m[i] = arr[i];
    end
    repeat (2) @(posedge i_clk);
    rst_n <= 1'b1;
    #1;
    chk("oe_n", {7'h00, oe_n}, 8'h01);
    reg_io(1'b0, 2'h0, 8'h00);
    chk("ctrl", rdata, 8'h01);
    reg_io(1'b0, 2'h3, 8'h00);
    chk("unmapped", rdata, 8'h00);
    $display("test reset done");
    wr_seq(8'h1e, 3, 1'b1);
    chk("prog", 8'(progs), 8'h01);
    reg_io(1'b0, 2'h2, 8'h00);
    chk("addr", rdata, 8'h11);
    probe({DT, SEL, 1'b0});
    for (int k = 0; k < 200 && busy; k++) @(posedge i_clk);
    if (busy) begin
      err_count++;
      test_done();
    end
    chk("stby", {7'h00, standby}, 8'h00);
    i_mst.stop();
    repeat (5) @(posedge i_clk);
    chk("stby", {7'h00, standby}, 8'h01);
    $display("test write done");
    rd_seq(8'h0f, 2);
    rd_seq(8'h1e, 3);
    $display("test read done");
    probe({DT, SEL ^ 3'b001, 1'b0});
    probe({DT ^ 4'h8, SEL, 1'b0});
    reg_io(1'b1, 2'h0, 8'h00);
    probe({DT, SEL, 1'b0});
    reg_io(1'b1, 2'h0, 8'h01);
    // Clock enable low: read strobe must be lost
    @(posedge i_clk);
    ce <= 1'b0;
    reg_io(1'b0, 2'h0, 8'h00);
    chk("frozen", rdata, 8'h00);
    @(posedge i_clk);
    ce <= 1'b1;
    $display("test select done");
    @(posedge i_clk);
    wp <= 1'b1;
    wr_seq(8'h80, 1, 1'b0);
    chk("prog", 8'(progs), 8'h01);
    rd_seq(8'h80, 1);
    chk("queue", 8'(q.size()), 8'h00);
    $display("test protect done");
    test_done();
  end
endmodule
`default_nettype wire
